// ---- verilog/usc_consts.vh ----
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH

// ***************************************************************
// register indices (byte address = index * 4)
// ***************************************************************
`define USC_IDX_TX_HOLD 10'h0B8
`define USC_IDX_RX_HOLD 10'h0B9
`define USC_IDX_CTRL_STATUS 10'h0BA
`define USC_IDX_RX_CTRL_STATUS 10'h0BB
`define USC_IDX_IRQ_CLOCK_SOURCE 10'h0BC
`define USC_IDX_BAUD_DIV 10'h0BD

// ***************************************************************
// uart_ctrl_status fields
// ***************************************************************
`define USC_CS_PARITY_ENABLE 7
`define USC_CS_PARITY_SELECT_HI 6
`define USC_CS_TX_NINTH_BIT 5
`define USC_CS_FRAME_LEN_SEL_HI 4
`define USC_CS_FRAME_LEN_SEL_LO 3
`define USC_CS_ERROR 2
`define USC_CS_RX_BUFFER_FULL 1
`define USC_CS_TX_BUFFER_EMPTY 0

// ***************************************************************
// uart_rx_ctrl_status fields
// ***************************************************************
`define USC_RS_OVERRUN_ERROR 7
`define USC_RS_FRAMING_ERROR 6
`define USC_RS_PARITY_ERROR 5
`define USC_RS_SPARE 4
`define USC_RS_RX_NINTH_BIT 3
`define USC_RS_ATTENTION_MODE 2
`define USC_RS_TRANSMITTING_FLAG 1
`define USC_RS_RX_BREAK_FLAG 0

// ***************************************************************
// uart_irq_clock_source fields
// ***************************************************************
`define USC_IC_TWO_STOP_SELECT 7
`define USC_IC_SHORT_STOP_SELECT 6
`define USC_IC_TX_PIN_ENABLE 5
`define USC_IC_SYNC_MODE 4
`define USC_IC_RX_EXT_CLOCK_SELECT 3
`define USC_IC_TX_EXT_CLOCK_SELECT 2
`define USC_IC_RX_IRQ_ENABLE 1
`define USC_IC_TX_IRQ_ENABLE 0

// ***************************************************************
// reset values
// ***************************************************************
`define USC_RST_CTRL 8'h00
`define USC_RST_IRQ_CLOCK 8'h00
`define USC_RST_BAUD_DIV 11'h000
`define USC_RST_TX_BUFFER_EMPTY 1'b1

// ***************************************************************
// frame length codes and bit timing in oversample ticks
// ***************************************************************
`define USC_LEN_EIGHT 2'h0
`define USC_LEN_SEVEN 2'h1
`define USC_LEN_NINE 2'h2
`define USC_LEN_LOOPBACK 2'h3
`define USC_TICK_LAST_FULL 4'hF
`define USC_TICK_LAST_SHORT 4'hD
`define USC_TICK_MID 4'h7

`endif

// ---- verilog/usc_usart_regs.v ----
`timescale 1ns/1ps
`include "usc_consts.vh"

// Behaviour
// - parity only when enabled and 7/8-bit frames
// - select: odd, even, mark one, space zero
// - shared bit: ninth tx bit or parity select
// - length code: 8, 7, 9 bits, loopback
// - loopback feeds tx into rx, nine bits
// - error summary flag set by any error
// - rx full set on copy, cleared on read
// - tx empty set on transfer, cleared on write
// - error flags sticky, cleared by status read
// - received ninth bit kept in status
// - attention cleared by ninth-bit-set character
// - transmitting flag ends after last stop
// - break flag on framing error until high
// - stop count bit: one or two stops
// - short stop makes last stop 7/8 bit in async mode
// - pin enable hands pin to transmitter
// - mode bit: async zero, sync one
// - rx clock internal or external pin
// - tx clock internal or external pin
// - rx interrupt enable gates receiver interrupt
// - tx interrupt enable gates transmitter interrupt
// - tx pending while empty and enabled
// - rx pending while full and enabled
// - async clock is sixteen times baud
module usc_usart_regs (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // serial pins
  input wire SERIAL_IN_PIN,
  output wire SERIAL_OUT_PIN,
  output wire SERIAL_OUT_OE_N,
  input wire EXT_BAUD_CLOCK_PIN,
  // interrupt requests
  output wire TX_IRQ_PEND,
  output wire RX_IRQ_PEND
);

  localparam T_IDLE = 3'h0;
  localparam T_START = 3'h1;
  localparam T_DATA = 3'h2;
  localparam T_PAR = 3'h3;
  localparam T_STOP = 3'h4;
  localparam R_IDLE = 2'h0;
  localparam R_START = 2'h1;
  localparam R_BITS = 2'h2;
  localparam R_STOP = 2'h3;

  // ***************************************************************
  // state
  // ***************************************************************
  reg [7:0] ctrl_r;
  reg [7:0] irqclk_r;
  reg [10:0] baud_div_r;
  reg [10:0] baud_cnt_r;
  reg [7:0] tx_hold_r;
  reg [7:0] rx_hold_r;
  reg tx_buffer_empty_r, rx_buffer_full_r, doe_r, fe_r, pe_r, spare_r, rx_ninth_bit_r, attention_mode_r, transmitting_flag_r, rx_break_flag_r;
  reg [31:0] prdata_r;
  reg rd_clr_rx_buffer_full_r;
  reg [2:0] rd_clr_err_r;
  reg in_s1_r, in_s2_r, ck_s1_r, ck_s2_r, ck_d_r;
  reg [2:0] tx_st_r;
  reg [3:0] tx_cnt_r, tx_idx_r;
  reg [8:0] tx_sh_r;
  reg tx_stop_num_r;
  reg [1:0] rx_st_r;
  reg [3:0] rx_cnt_r, rx_idx_r;
  reg [9:0] rx_sh_r;

  // ***************************************************************
  // frame format
  // ***************************************************************
  wire [1:0] len_code = {ctrl_r[`USC_CS_FRAME_LEN_SEL_HI], ctrl_r[`USC_CS_FRAME_LEN_SEL_LO]};
  wire loopback = (len_code == `USC_LEN_LOOPBACK);
  wire nine_bit = (len_code == `USC_LEN_NINE) || loopback;
  wire seven_bit = (len_code == `USC_LEN_SEVEN);
  wire par_on = ctrl_r[`USC_CS_PARITY_ENABLE] && !nine_bit;
  wire [3:0] n_data = nine_bit ? 4'h9 : (seven_bit ? 4'h7 : 4'h8);
  wire [3:0] n_bits = n_data + {3'h0, par_on};
  wire sync_mode = irqclk_r[`USC_IC_SYNC_MODE];
  wire psel_hi = ctrl_r[`USC_CS_PARITY_SELECT_HI];
  wire psel_lo = ctrl_r[`USC_CS_TX_NINTH_BIT];

  function par_calc;
    input [7:0] d;
    input hi;
    input lo;
    begin
      case ({hi, lo})
        2'h0: par_calc = ~^d;
        2'h1: par_calc = ^d;
        2'h2: par_calc = 1'b1;
        default: par_calc = 1'b0;
      endcase
    end
  endfunction

  // ***************************************************************
  // apb access
  // ***************************************************************
  wire [9:0] idx = PADDR[11:2];
  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE;
  wire hit = (idx == `USC_IDX_TX_HOLD) || (idx == `USC_IDX_RX_HOLD) ||
             (idx == `USC_IDX_CTRL_STATUS) || (idx == `USC_IDX_RX_CTRL_STATUS) ||
             (idx == `USC_IDX_IRQ_CLOCK_SOURCE) || (idx == `USC_IDX_BAUD_DIV);
  wire wr = access && PWRITE && hit;
  wire wr_tx_hold = wr && (idx == `USC_IDX_TX_HOLD);
  wire err_any = doe_r || fe_r || pe_r;

  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit;
  assign PRDATA = prdata_r;

  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (idx)
      `USC_IDX_TX_HOLD: rd_val = tx_hold_r;
      `USC_IDX_RX_HOLD: rd_val = rx_hold_r;
      `USC_IDX_CTRL_STATUS: rd_val = {ctrl_r[7:3], err_any, rx_buffer_full_r, tx_buffer_empty_r};
      `USC_IDX_RX_CTRL_STATUS: rd_val = {doe_r, fe_r, pe_r, spare_r, rx_ninth_bit_r, attention_mode_r,
                                         transmitting_flag_r, rx_break_flag_r};
      `USC_IDX_IRQ_CLOCK_SOURCE: rd_val = irqclk_r;
      default: rd_val = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle; clear-on-read only drops
  // the bits that were actually returned, so nothing set meanwhile is lost
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      prdata_r <= 32'h00000000;
      rd_clr_rx_buffer_full_r <= 1'b0;
      rd_clr_err_r <= 3'h0;
    end else if (setup) begin
      if (!PWRITE && idx == `USC_IDX_BAUD_DIV)
        prdata_r <= {21'h00000, baud_div_r};
      else if (!PWRITE)
        prdata_r <= {24'h000000, rd_val};
      else
        prdata_r <= 32'h00000000;
      rd_clr_rx_buffer_full_r <= !PWRITE && idx == `USC_IDX_RX_HOLD && rx_buffer_full_r;
      rd_clr_err_r <= (!PWRITE && idx == `USC_IDX_RX_CTRL_STATUS) ?
                      {doe_r, fe_r, pe_r} : 3'h0;
    end
  end

  wire rd_access = access && !PWRITE;
  wire clr_rx_buffer_full = rd_access && rd_clr_rx_buffer_full_r;
  wire [2:0] clr_err = rd_access ? rd_clr_err_r : 3'h0;

  // ***************************************************************
  // input synchronisers and baud ticks
  // ***************************************************************
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      in_s1_r <= 1'b1;
      in_s2_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_d_r <= 1'b0;
    end else begin
      in_s1_r <= SERIAL_IN_PIN;
      in_s2_r <= in_s1_r;
      ck_s1_r <= EXT_BAUD_CLOCK_PIN;
      ck_s2_r <= ck_s1_r;
      ck_d_r <= ck_s2_r;
    end
  end

  // a divisor of zero stops the internal clock (power-down)
  wire int_tick = (baud_div_r != 11'h000) && (baud_cnt_r == baud_div_r);
  always @(posedge REF_CLK) begin
    if (!RESETN)
      baud_cnt_r <= 11'h000;
    else if (int_tick || baud_div_r == 11'h000)
      baud_cnt_r <= 11'h000;
    else
      baud_cnt_r <= baud_cnt_r + 11'h001;
  end

  wire ck_rise = ck_s2_r && !ck_d_r;
  wire ck_fall = !ck_s2_r && ck_d_r;
  // with external clocks, sync mode sends on the rising and samples on the falling edge
  wire tx_tick = irqclk_r[`USC_IC_TX_EXT_CLOCK_SELECT] ? ck_rise : int_tick;
  wire rx_tick = irqclk_r[`USC_IC_RX_EXT_CLOCK_SELECT] ?
                 (sync_mode ? ck_fall : ck_rise) : int_tick;

  // ***************************************************************
  // transmitter
  // ***************************************************************
  wire tx_last_stop = (tx_stop_num_r == irqclk_r[`USC_IC_TWO_STOP_SELECT]);
  wire short_stop = irqclk_r[`USC_IC_SHORT_STOP_SELECT] && !sync_mode;
  wire [3:0] tx_bit_last = sync_mode ? 4'h0 :
                           ((tx_st_r == T_STOP && tx_last_stop && short_stop) ?
                            `USC_TICK_LAST_SHORT : `USC_TICK_LAST_FULL);
  wire tx_bit_end = tx_tick && (tx_cnt_r == tx_bit_last);
  wire tx_load = (tx_st_r == T_IDLE) && !tx_buffer_empty_r;
  wire tx_done = (tx_st_r == T_STOP) && tx_bit_end && tx_last_stop;

  reg tx_line;
  always @* begin
    case (tx_st_r)
      T_START: tx_line = 1'b0;
      T_DATA: tx_line = tx_sh_r[tx_idx_r];
      T_PAR: tx_line = par_calc(tx_sh_r[7:0] & {!seven_bit, 7'h7F}, psel_hi, psel_lo);
      default: tx_line = 1'b1;
    endcase
  end

  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      tx_st_r <= T_IDLE;
      tx_cnt_r <= 4'h0;
      tx_idx_r <= 4'h0;
      tx_sh_r <= 9'h000;
      tx_stop_num_r <= 1'b0;
    end else begin
      case (tx_st_r)
        T_IDLE: begin
          if (tx_load) begin
            tx_sh_r <= {ctrl_r[`USC_CS_TX_NINTH_BIT], tx_hold_r};
            tx_st_r <= T_START;
            tx_cnt_r <= 4'h0;
          end
        end
        T_START, T_DATA, T_PAR, T_STOP: begin
          if (tx_bit_end) begin
            tx_cnt_r <= 4'h0;
            case (tx_st_r)
              T_START: begin
                tx_st_r <= T_DATA;
                tx_idx_r <= 4'h0;
              end
              T_DATA: begin
                tx_idx_r <= tx_idx_r + 4'h1;
                if (tx_idx_r == n_data - 4'h1) begin
                  tx_st_r <= par_on ? T_PAR : T_STOP;
                  tx_stop_num_r <= 1'b0;
                end
              end
              T_PAR: begin
                tx_st_r <= T_STOP;
                tx_stop_num_r <= 1'b0;
              end
              default: begin
                if (tx_last_stop)
                  tx_st_r <= T_IDLE;
                else
                  tx_stop_num_r <= 1'b1;
              end
            endcase
          end else if (tx_tick) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
          end
        end
        default: tx_st_r <= T_IDLE;
      endcase
    end
  end

  assign SERIAL_OUT_PIN = tx_line;
  assign SERIAL_OUT_OE_N = !irqclk_r[`USC_IC_TX_PIN_ENABLE];

  // ***************************************************************
  // receiver
  // ***************************************************************
  wire rx_line = loopback ? tx_line : in_s2_r;
  wire [3:0] rx_bit_last = sync_mode ? 4'h0 : `USC_TICK_LAST_FULL;
  wire [3:0] rx_mid = sync_mode ? 4'h0 : `USC_TICK_MID;
  wire rx_sample = rx_tick && (rx_cnt_r == rx_bit_last);
  wire rx_end = (rx_st_r == R_STOP) && rx_sample;
  wire [7:0] rx_data = rx_sh_r[7:0] & {!seven_bit, 7'h7F};
  wire rx_ninth = nine_bit && rx_sh_r[8];
  wire rx_fe = rx_end && !rx_line;
  wire rx_pe = rx_end && par_on &&
               (rx_sh_r[n_data] != par_calc(rx_data, psel_hi, psel_lo));
  // attention mode drops characters whose ninth bit is clear
  wire rx_keep = !(attention_mode_r && nine_bit && !rx_sh_r[8]);
  wire rx_done = rx_end && rx_keep;
  wire rx_ovr = rx_done && rx_buffer_full_r && !clr_rx_buffer_full;

  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      rx_st_r <= R_IDLE;
      rx_cnt_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 10'h000;
    end else begin
      case (rx_st_r)
        R_IDLE: begin
          if (rx_tick && !rx_line && !rx_break_flag_r) begin
            rx_st_r <= sync_mode ? R_BITS : R_START;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 10'h000;
            if (sync_mode) begin
              rx_sh_r[0] <= rx_line;
              rx_idx_r <= 4'h1;
              if (n_bits == 4'h1)
                rx_st_r <= R_STOP;
            end
          end
        end
        R_START: begin
          if (rx_tick && rx_cnt_r == rx_mid) begin
            rx_cnt_r <= 4'h0;
            rx_st_r <= rx_line ? R_IDLE : R_BITS; // false start rejected
          end else if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
          end
        end
        R_BITS, R_STOP: begin
          if (rx_sample) begin
            rx_cnt_r <= 4'h0;
            if (rx_st_r == R_STOP) begin
              rx_st_r <= R_IDLE;
            end else begin
              rx_sh_r[rx_idx_r] <= rx_line;
              rx_idx_r <= rx_idx_r + 4'h1;
              if (rx_idx_r == n_bits - 4'h1)
                rx_st_r <= R_STOP;
            end
          end else if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
          end
        end
        default: rx_st_r <= R_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // registers and flags
  // ***************************************************************
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      ctrl_r <= `USC_RST_CTRL;
      irqclk_r <= `USC_RST_IRQ_CLOCK;
      baud_div_r <= `USC_RST_BAUD_DIV;
      tx_hold_r <= 8'h00;
      rx_hold_r <= 8'h00;
      tx_buffer_empty_r <= `USC_RST_TX_BUFFER_EMPTY;
      rx_buffer_full_r <= 1'b0;
      doe_r <= 1'b0;
      fe_r <= 1'b0;
      pe_r <= 1'b0;
      spare_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      attention_mode_r <= 1'b0;
      transmitting_flag_r <= 1'b0;
      rx_break_flag_r <= 1'b0;
    end else begin
      if (wr && idx == `USC_IDX_CTRL_STATUS)
        ctrl_r <= {PWDATA[7:3], 3'h0};
      if (wr && idx == `USC_IDX_IRQ_CLOCK_SOURCE)
        irqclk_r <= PWDATA[7:0];
      if (wr && idx == `USC_IDX_BAUD_DIV)
        baud_div_r <= PWDATA[10:0];
      if (wr_tx_hold)
        tx_hold_r <= PWDATA[7:0];
      // a write in the load cycle refills the buffer, so it stays full
      if (wr_tx_hold)
        tx_buffer_empty_r <= 1'b0;
      else if (tx_load)
        tx_buffer_empty_r <= 1'b1;
      if (tx_load)
        transmitting_flag_r <= 1'b1;
      else if (tx_done && tx_buffer_empty_r)
        transmitting_flag_r <= 1'b0;
      // overrun keeps the unread character
      if (rx_done && !rx_ovr) begin
        rx_hold_r <= rx_data;
        rx_ninth_bit_r <= rx_ninth;
        rx_buffer_full_r <= 1'b1;
      end else if (clr_rx_buffer_full) begin
        rx_buffer_full_r <= 1'b0;
      end
      doe_r <= rx_ovr || (doe_r && !clr_err[2]);
      fe_r <= (rx_fe && rx_keep) || (fe_r && !clr_err[1]);
      pe_r <= (rx_pe && rx_keep) || (pe_r && !clr_err[0]);
      if (wr && idx == `USC_IDX_RX_CTRL_STATUS) begin
        spare_r <= PWDATA[`USC_RS_SPARE];
        attention_mode_r <= PWDATA[`USC_RS_ATTENTION_MODE];
      end
      if (rx_end && rx_ninth)
        attention_mode_r <= 1'b0;
      if (rx_fe)
        rx_break_flag_r <= 1'b1;
      else if (rx_line)
        rx_break_flag_r <= 1'b0;
    end
  end

  assign TX_IRQ_PEND = tx_buffer_empty_r && irqclk_r[`USC_IC_TX_IRQ_ENABLE];
  assign RX_IRQ_PEND = rx_buffer_full_r && irqclk_r[`USC_IC_RX_IRQ_ENABLE];

endmodule // usc_usart_regs

// ---- sim/usc_usart_regs_asserts.sv ----
`timescale 1ns/1ps
`include "usc_consts.vh"

// ************************************
// port checks
// ************************************
module usc_usart_regs_asserts (
  // clock and reset
  input logic REF_CLK,
  input logic RESETN,
  // apb slave
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  input logic PREADY,
  input logic PSLVERR,
  // serial pins
  input logic SERIAL_IN_PIN,
  input logic SERIAL_OUT_PIN,
  input logic SERIAL_OUT_OE_N,
  input logic EXT_BAUD_CLOCK_PIN,
  // interrupt requests
  input logic TX_IRQ_PEND,
  input logic RX_IRQ_PEND
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence irq_off_s(b);
    PSEL && PENABLE && PWRITE && PADDR[11:2] == `USC_IDX_IRQ_CLOCK_SOURCE && !PWDATA[b];
  endsequence
  sequence tx_load_s;
    PSEL && PENABLE && PWRITE && PADDR[11:2] == `USC_IDX_TX_HOLD;
  endsequence
  sequence rx_take_s;
    PSEL && PENABLE && !PWRITE && PADDR[11:2] == `USC_IDX_RX_HOLD;
  endsequence

  idle_reset_a: assert property ($rose(RESETN) |->
    SERIAL_OUT_PIN && SERIAL_OUT_OE_N && !TX_IRQ_PEND && !RX_IRQ_PEND)
    else $error("outputs not idle after reset");
  zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase not ready");
  err_access_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error response outside access");
  read_upper_a: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:11] == 21'h0)
    else $error("upper read bits not zero");
  pin_hand_a: assert property (
    PSEL && PENABLE && PWRITE && PADDR[11:2] == `USC_IDX_IRQ_CLOCK_SOURCE
    |=> SERIAL_OUT_OE_N == !$past(PWDATA[5]))
    else $error("pin enable not followed");
  tx_gate_a: assert property (irq_off_s(0) |=> !TX_IRQ_PEND)
    else $error("tx interrupt not blocked");
  rx_gate_a: assert property (irq_off_s(1) |=> !RX_IRQ_PEND)
    else $error("rx interrupt not blocked");
  tx_fill_a: assert property (tx_load_s |=> !TX_IRQ_PEND)
    else $error("tx interrupt after buffer write");
  rx_drain_a: assert property (rx_take_s |=> !RX_IRQ_PEND)
    else $error("rx interrupt after buffer read");
endmodule // usc_usart_regs_asserts

bind usc_usart_regs usc_usart_regs_asserts u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SERIAL_IN_PIN(SERIAL_IN_PIN),
  .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
  .EXT_BAUD_CLOCK_PIN(EXT_BAUD_CLOCK_PIN), .TX_IRQ_PEND(TX_IRQ_PEND),
  .RX_IRQ_PEND(RX_IRQ_PEND));

// ---- sim/usc_serial_partner.sv ----
`timescale 1ns/1ps

// ************************************
// serial far end
// ************************************
module usc_serial_partner #(
  // 16 ticks of 8 cycles each
  parameter int BIT_CYCLES = 128
) (
  // clock
  input logic clk,
  // serial lines
  input logic tx_line,
  output logic rx_line,
  output logic ext_clk
);
  // external clock stands still: frames use the internal divider only
  initial begin
    rx_line = 1'b1;
    ext_clk = 1'b0;
  end

  task automatic send(input logic [8:0] d, input int n, input logic stop, input int len);
    int i;
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BIT_CYCLES) @(posedge clk);
    for (i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    rx_line <= stop;
    repeat (len) @(posedge clk);
    rx_line <= 1'b1;
  endtask

  // samples at mid-bit, far from the edges where the line may move
  task automatic capture(output logic [9:0] d, input int n);
    int i;
    d = 10'h000;
    @(posedge clk);
    while (tx_line !== 1'b0) @(posedge clk);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (i = 0; i < n; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      d[i] = tx_line;
    end
  endtask
endmodule // usc_serial_partner

// ---- sim/test_usc_usart_regs.sv ----
`timescale 1ns/1ps
`include "usc_consts.vh"

// ************************************
// register and frame tests
// ************************************
module test_usc_usart_regs;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err_v;
  logic rx_pin, tx_pin, tx_oe_n, ext_clk, tx_irq, rx_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [9:0] got;
  logic [7:0] d;
  int errors = 0, comparisons = 0, cycles = 0, t0, k, p;
  // pulled high while the pin is not handed over
  wire tx_line = tx_oe_n ? 1'b1 : tx_pin;

  usc_usart_regs dut (.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL_IN_PIN(rx_pin), .SERIAL_OUT_PIN(tx_pin),
    .SERIAL_OUT_OE_N(tx_oe_n), .EXT_BAUD_CLOCK_PIN(ext_clk), .TX_IRQ_PEND(tx_irq),
    .RX_IRQ_PEND(rx_irq));
  usc_serial_partner partner (.clk(clk), .tx_line(tx_line), .rx_line(rx_pin),
    .ext_clk(ext_clk));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [10:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {21'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tx_frame(input logic [7:0] c, input logic [7:0] dv, input int n,
                          input logic [9:0] exp, input int rem);
    apb(1'b1, `USC_IDX_CTRL_STATUS, {3'h0, c});
    fork
      partner.capture(got, n);
      apb(1'b1, `USC_IDX_TX_HOLD, {3'h0, dv});
    join
    t0 = cycles;
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    while (rd_v[1] === 1'b1 && cycles - t0 < 4000) apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("tx bits", got, exp);
    // start bit may end up to one tick early, so the mid-stop capture runs late
    check("tx busy", (cycles - t0 >= rem - 9) && (cycles - t0 <= rem + 8), 1);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `USC_IDX_CTRL_STATUS, 11'h0);
    check("ctrl reset", rd_v, 32'h01);
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("rx status reset", rd_v, 32'h00);
    apb(1'b0, `USC_IDX_IRQ_CLOCK_SOURCE, 11'h0);
    check("irq reset", rd_v, 32'h00);
    apb(1'b0, 10'h000, 11'h0);
    check("unmapped", {err_v, rd_v[30:0]}, 32'h80000000);
    apb(1'b1, `USC_IDX_CTRL_STATUS, 11'h0FF);
    apb(1'b0, `USC_IDX_CTRL_STATUS, 11'h0);
    check("ctrl ro bits", rd_v, 32'hF9);
    apb(1'b1, `USC_IDX_RX_CTRL_STATUS, 11'h0EB); // reserved bit kept zero
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("rx status ro", rd_v, 32'h00);
    apb(1'b1, `USC_IDX_IRQ_CLOCK_SOURCE, 11'h01E);
    apb(1'b0, `USC_IDX_IRQ_CLOCK_SOURCE, 11'h0);
    check("irq rw", rd_v, 32'h1E);
    apb(1'b1, `USC_IDX_BAUD_DIV, 11'h007);
    apb(1'b1, `USC_IDX_IRQ_CLOCK_SOURCE, 11'h021);
    @(negedge clk);
    check("rx irq idle", rx_irq, 1'b0);
    check("tx irq", tx_irq, 1'b1);
    check("pin handed", tx_oe_n, 1'b0);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, `USC_IDX_IRQ_CLOCK_SOURCE, {3'h0, k[1:0], 6'h21});
      tx_frame(8'h00, 8'h96, 9, 10'h196, 64 + (k / 2) * 128 - (k % 2) * 16);
    end
    apb(1'b1, `USC_IDX_IRQ_CLOCK_SOURCE, 11'h023);
    for (p = 0; p < 8; p++) begin
      d = (p < 4) ? 8'hA4 : 8'hA5;
      tx_frame({1'b1, p[1:0], 5'h00}, d, 10,
               {1'b1, p[1] ? ~p[0] : ((^d) ^ ~p[0]), d}, 64);
    end
    tx_frame(8'hA8, 8'h83, 9, 10'h103, 64);
    tx_frame(8'hB0, 8'h5A, 10, 10'h35A, 64);
    apb(1'b1, `USC_IDX_CTRL_STATUS, 11'h000);
    partner.send(9'h03C, 8, 1'b1, 128);
    apb(1'b0, `USC_IDX_CTRL_STATUS, 11'h0);
    check("rx full", rd_v, 32'h03);
    @(negedge clk);
    check("rx irq", rx_irq, 1'b1);
    apb(1'b0, `USC_IDX_RX_HOLD, 11'h0);
    check("rx data", rd_v, 32'h3C);
    @(negedge clk);
    check("rx irq off", rx_irq, 1'b0);
    partner.send(9'h011, 8, 1'b1, 128);
    partner.send(9'h022, 8, 1'b1, 128);
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("overrun", rd_v, 32'h80);
    apb(1'b0, `USC_IDX_RX_HOLD, 11'h0);
    check("old kept", rd_v, 32'h11);
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("overrun clear", rd_v, 32'h00);
    fork
      partner.send(9'h055, 8, 1'b0, 384);
      begin
        repeat (1408) @(posedge clk);
        apb(1'b0, `USC_IDX_CTRL_STATUS, 11'h0);
        check("error sum", rd_v[2], 1'b1);
        apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
        check("framing", rd_v, 32'h41);
      end
    join
    apb(1'b0, `USC_IDX_RX_HOLD, 11'h0);
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("status clear", rd_v, 32'h00);
    apb(1'b0, `USC_IDX_CTRL_STATUS, 11'h0);
    check("error sum clear", rd_v[2], 1'b0);
    apb(1'b1, `USC_IDX_RX_CTRL_STATUS, 11'h004); // reserved bit kept zero
    apb(1'b1, `USC_IDX_CTRL_STATUS, 11'h038);
    apb(1'b1, `USC_IDX_TX_HOLD, 11'h0C3);
    repeat (1600) @(posedge clk);
    apb(1'b0, `USC_IDX_RX_HOLD, 11'h0);
    check("loop data", rd_v, 32'hC3);
    apb(1'b0, `USC_IDX_RX_CTRL_STATUS, 11'h0);
    check("ninth attention_mode", rd_v, 32'h08);
    give_verdict;
  end
endmodule // test_usc_usart_regs
